// [hdl/fpc_ctrl.sv]
/*
 * Fractional loop control: reset and self-reset, lock detection, digital
 * oscillator model, post divider, fraction modulator and all dividers.
 * Assumes clk_in is the reference; the oscillator is modelled as a tick
 * enable, so its rate cannot exceed clk_in (multiplier over prescale <= 1).
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_ctrl
   import fpc_pkg::*;
#(
   parameter int NUM_OUT     = 4,
   parameter int CAPTURE_IDX = 0
)(
   input  wire logic                           clk_in,
   input  wire logic                           rst_n_in,
   input  wire logic                           resync_in,
   input  wire logic                           self_reset_en_in,
   input  wire fpc_pkg::fpc_comp_t             comp_mode_in,
   input  wire logic                           frac_mode_in,
   input  wire logic [1:0]                     frac_width_in,
   input  wire logic [fpc_pkg::FRAC_W-1:0]     frac_num_in,
   input  wire logic                           pre_bypass_in,
   input  wire logic [fpc_pkg::CNT_W-1:0]      pre_hi_in,
   input  wire logic [fpc_pkg::CNT_W-1:0]      pre_lo_in,
   input  wire logic                           mul_bypass_in,
   input  wire logic [fpc_pkg::CNT_W-1:0]      mul_hi_in,
   input  wire logic [fpc_pkg::CNT_W-1:0]      mul_lo_in,
   input  wire logic                           post_div_en_in,
   input  wire logic [NUM_OUT-1:0]             out_bypass_in,
   input  wire logic [NUM_OUT-1:0][fpc_pkg::CNT_W-1:0] out_hi_in,
   input  wire logic [NUM_OUT-1:0][fpc_pkg::CNT_W-1:0] out_lo_in,
   output logic                                locked_out,
   output logic                                fb_clk_out,
   output logic [NUM_OUT-1:0]                  clk_out
);
   import fpc_pkg::*;

   typedef struct packed {
      fpc_loop_t           state;
      logic [TUNE_W-1:0]   tune;
      logic [TUNE_W-1:0]   nco;
      logic                post_tgl;
      logic                ref_lead;
      logic                fb_lead;
      logic [GAP_W-1:0]    gap;
      logic [GOOD_W-1:0]   good;
      logic [SRST_W-1:0]   srst;
      logic [FRAC_W-1:0]   frac_acc;
      logic                frac_extra;
      logic                fb_o;
      logic [NUM_OUT-1:0]  clk_o;
   } fpc_ctrl_st_t;

   fpc_ctrl_st_t st_ff;
   fpc_ctrl_st_t nxt_st;

   logic               in_rst;
   logic [TUNE_W:0]    nco_sum;
   logic               osc_tick;
   logic               post_tick;
   logic               ref_p;
   logic               fb_p;
   logic               pre_lvl;
   logic               mul_lvl;
   logic [NUM_OUT-1:0] out_lvl;
   logic [FRAC_W-1:0]  frac_scaled;
   logic [FRAC_W:0]    frac_sum;
   logic               match;
   logic               match_good;
   logic               slip;
   logic               loss_evt;
   logic               speed_up;
   logic               slow_down;

   // ----------------------------------------
   // Reset, oscillator, post divider
   // ----------------------------------------
   assign in_rst    = resync_in || (st_ff.srst != '0);
   assign nco_sum   = {1'b0, st_ff.nco} + {1'b0, st_ff.tune};
   assign osc_tick  = !in_rst && nco_sum[TUNE_W];
   assign post_tick = post_div_en_in ? (osc_tick && st_ff.post_tgl) : osc_tick;

   // ----------------------------------------
   // Dividers
   // ----------------------------------------
   // Prescale has no duty-cycle use; only its wrap pulse is taken.
   fpc_div u_pre (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .clear_in  (in_rst),
      .tick_in   (!in_rst),
      .bypass_in (pre_bypass_in),
      .hi_in     (pre_hi_in),
      .lo_in     (pre_lo_in),
      .extra_in  (1'b0),
      .level_out (pre_lvl),
      .wrap_out  (ref_p)
   );

   fpc_div u_mul (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .clear_in  (in_rst),
      .tick_in   (osc_tick),
      .bypass_in (mul_bypass_in),
      .hi_in     (mul_hi_in),
      .lo_in     (mul_lo_in),
      .extra_in  (st_ff.frac_extra),
      .level_out (mul_lvl),
      .wrap_out  (fb_p)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
         // Equal high and low counts give the half-high, half-low waveform.
         fpc_div u_post (
            .clk_in    (clk_in),
            .rst_n_in  (rst_n_in),
            .clear_in  (in_rst),
            .tick_in   (post_tick),
            .bypass_in (out_bypass_in[gi]),
            .hi_in     (out_hi_in[gi]),
            .lo_in     (out_lo_in[gi]),
            .extra_in  (1'b0),
            .level_out (out_lvl[gi]),
            .wrap_out  ()
         );
      end
   endgenerate

   // ----------------------------------------
   // Fraction modulator
   // ----------------------------------------
   always_comb begin
      case (frac_width_in)
         FW_8:    frac_scaled = {frac_num_in[7:0], 24'h000000};
         FW_16:   frac_scaled = {frac_num_in[15:0], 16'h0000};
         FW_24:   frac_scaled = {frac_num_in[23:0], 8'h00};
         default: frac_scaled = frac_num_in;
      endcase
   end
   assign frac_sum = {1'b0, st_ff.frac_acc} + {1'b0, frac_scaled};

   // ----------------------------------------
   // Phase compare
   // ----------------------------------------
   always_comb begin
      match     = 1'b0;
      slip      = 1'b0;
      speed_up  = 1'b0;
      slow_down = 1'b0;
      if (ref_p && fb_p) begin
         match = 1'b1;
      end else if (ref_p) begin
         match     = st_ff.fb_lead;
         slip      = st_ff.ref_lead;
         slow_down = st_ff.fb_lead;
         speed_up  = !st_ff.fb_lead;
      end else if (fb_p) begin
         match     = st_ff.ref_lead;
         slip      = st_ff.fb_lead;
         speed_up  = st_ff.ref_lead;
         slow_down = !st_ff.ref_lead;
      end
   end
   // A coincident pair has no gap even if a stale lead flag is set.
   assign match_good = match && ((ref_p && fb_p) || st_ff.gap <= LOCK_WIN);
   assign loss_evt   = !in_rst && (st_ff.state == LS_LOCKED) &&
                       (slip || (match && !match_good) || st_ff.gap > LOSS_WIN);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.srst != '0) begin
         nxt_st.srst = st_ff.srst - SRST_W'(1);
      end
      if (in_rst) begin
         nxt_st.state      = LS_RESET;
         nxt_st.tune       = NOMINAL_TUNE;
         nxt_st.nco        = '0;
         nxt_st.post_tgl   = 1'b0;
         nxt_st.ref_lead   = 1'b0;
         nxt_st.fb_lead    = 1'b0;
         nxt_st.gap        = '0;
         nxt_st.good       = '0;
         nxt_st.frac_acc   = '0;
         nxt_st.frac_extra = 1'b0;
      end else begin
         nxt_st.nco = nco_sum[TUNE_W-1:0];
         if (osc_tick) begin
            nxt_st.post_tgl = ~st_ff.post_tgl;
         end
         if (fb_p) begin
            if (frac_mode_in) begin
               nxt_st.frac_acc   = frac_sum[FRAC_W-1:0];
               nxt_st.frac_extra = frac_sum[FRAC_W];
            end else begin
               nxt_st.frac_acc   = '0;
               nxt_st.frac_extra = 1'b0;
            end
         end
         if (!frac_mode_in) begin
            nxt_st.frac_extra = 1'b0;
         end
         if (speed_up && st_ff.tune < TUNE_MAX) begin
            nxt_st.tune = st_ff.tune + TUNE_STEP;
         end else if (slow_down && st_ff.tune > TUNE_MIN) begin
            nxt_st.tune = st_ff.tune - TUNE_STEP;
         end
         if (match || slip) begin
            nxt_st.ref_lead = 1'b0;
            nxt_st.fb_lead  = 1'b0;
            nxt_st.gap      = '0;
         end else if (ref_p || fb_p) begin
            nxt_st.ref_lead = ref_p;
            nxt_st.fb_lead  = fb_p;
            nxt_st.gap      = '0;
         end else if ((st_ff.ref_lead || st_ff.fb_lead) && st_ff.gap != GAP_MAX) begin
            nxt_st.gap = st_ff.gap + GAP_W'(1);
         end
         if (match_good && st_ff.good != LOCK_CNT) begin
            nxt_st.good = st_ff.good + GOOD_W'(1);
         end else if (slip || (match && !match_good)) begin
            nxt_st.good = '0;
         end
         case (st_ff.state)
            LS_RESET: begin
               nxt_st.state = LS_ACQUIRE;
            end
            LS_ACQUIRE: begin
               if (match_good && st_ff.good == LOCK_CNT - GOOD_W'(1)) begin
                  nxt_st.state = LS_LOCKED;
               end
            end
            LS_LOCKED: begin
               if (loss_evt) begin
                  nxt_st.state = LS_ACQUIRE;
                  nxt_st.good  = '0;
                  if (self_reset_en_in) begin
                     nxt_st.srst = SELF_RST_LEN;
                  end
               end
            end
            default: begin
               nxt_st.state = LS_RESET;
            end
         endcase
      end
      // Outputs are registered so they stay glitch-free into the core.
      nxt_st.fb_o = !in_rst && mul_lvl;
      for (int i = 0; i < NUM_OUT; i++) begin
         nxt_st.clk_o[i] = !in_rst &&
            (out_lvl[i] ^ (comp_mode_in == CM_SERIAL && i == CAPTURE_IDX));
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff       <= '0;
         st_ff.state <= LS_RESET;
         st_ff.tune  <= NOMINAL_TUNE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign locked_out = (st_ff.state == LS_LOCKED);
   assign fb_clk_out = st_ff.fb_o;
   assign clk_out    = st_ff.clk_o;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_loss_self;
      self_reset_en_in && loss_evt;
   endsequence
   sequence s_hold_rst;
      in_rst [*4];
   endsequence

   property p_resync_unlock;
      resync_in |=> (!locked_out && clk_out == '0 && !fb_clk_out);
   endproperty
   a_resync_unlock: assert property (p_resync_unlock) else $error("Resync left lock or clocks on");

   property p_resync_nominal;
      resync_in |=> (st_ff.tune == NOMINAL_TUNE);
   endproperty
   a_resync_nominal: assert property (p_resync_nominal) else $error("Tuning not nominal in reset");

   property p_release_unlocked;
      $fell(in_rst) |-> (!locked_out ##1 !locked_out);
   endproperty
   a_release_unlocked: assert property (p_release_unlocked) else $error("Lock right after release");

   property p_lock_cause;
      $rose(locked_out) |-> $past(match_good) && $past(st_ff.good) == LOCK_CNT - GOOD_W'(1);
   endproperty
   a_lock_cause: assert property (p_lock_cause) else $error("Lock without matched edges");

   property p_loss_drop;
      loss_evt |=> !locked_out;
   endproperty
   a_loss_drop: assert property (p_loss_drop) else $error("Lock held after loss");

   property p_self_reset;
      s_loss_self |=> s_hold_rst;
   endproperty
   a_self_reset: assert property (p_self_reset) else $error("Self-reset not applied");

   property p_integer;
      !frac_mode_in |=> !st_ff.frac_extra;
   endproperty
   a_integer: assert property (p_integer) else $error("Modulator active in integer mode");

   property p_frac_carry;
      (!in_rst && fb_p && frac_mode_in) |=> st_ff.frac_extra == $past(frac_sum[FRAC_W]);
   endproperty
   a_frac_carry: assert property (p_frac_carry) else $error("Fraction carry lost");

   property p_serial_invert;
      (!in_rst && comp_mode_in == CM_SERIAL)
         |=> clk_out[CAPTURE_IDX] == !$past(out_lvl[CAPTURE_IDX]);
   endproperty
   a_serial_invert: assert property (p_serial_invert) else $error("Capture clock not inverted");
endmodule
`default_nettype wire

// [hdl/fpc_div.sv]
/*
 * One programmable high/low counter, used for prescale, multiplier and outputs.
 * Assumes tick_in is a one-cycle enable at the rate to be divided.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_div
   import fpc_pkg::*;
(
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      clear_in,
   input  wire logic                      tick_in,
   input  wire logic                      bypass_in,
   input  wire logic [fpc_pkg::CNT_W-1:0] hi_in,
   input  wire logic [fpc_pkg::CNT_W-1:0] lo_in,
   input  wire logic                      extra_in,
   output logic                           level_out,
   output logic                           wrap_out
);
   import fpc_pkg::*;

   typedef struct packed {
      logic [PER_W-1:0] cnt;
      logic             high;
      logic             lvl;
   } fpc_div_st_t;

   fpc_div_st_t st_ff;
   fpc_div_st_t nxt_st;
   logic [PER_W-1:0] lim;
   logic [PER_W-1:0] cnt_inc;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_comb begin
      nxt_st   = st_ff;
      wrap_out = 1'b0;
      lim      = st_ff.high ? PER_W'(hi_in) : PER_W'(lo_in) + PER_W'(extra_in);
      cnt_inc  = st_ff.cnt + PER_W'(1);
      if (clear_in) begin
         nxt_st.cnt  = '0;
         nxt_st.high = 1'b1;
         nxt_st.lvl  = 1'b0;
      end else if (tick_in) begin
         if (bypass_in) begin
            nxt_st.lvl = ~st_ff.lvl;
            wrap_out   = 1'b1;
         end else if (cnt_inc >= lim) begin
            nxt_st.cnt  = '0;
            nxt_st.high = ~st_ff.high;
            nxt_st.lvl  = ~st_ff.high;
            wrap_out    = ~st_ff.high;
         end else begin
            nxt_st.cnt = cnt_inc;
            nxt_st.lvl = st_ff.high;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.lvl;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_phase_end;
      @(posedge clk_in) disable iff (!rst_n_in)
      (!clear_in && tick_in && !bypass_in && st_ff.high && (cnt_inc >= lim))
         |=> (!st_ff.high && st_ff.cnt == '0);
   endproperty
   a_phase_end: assert property (p_phase_end) else $error("High phase overran its count");

   property p_clear;
      @(posedge clk_in) disable iff (!rst_n_in)
      clear_in |=> (!level_out && st_ff.high && st_ff.cnt == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("Divider not cleared");
endmodule
`default_nettype wire

// [hdl/fpc_pkg.sv]
/*
 * Shared constants and types for the fractional loop control and its dividers.
 * Assumes one 125 MHz clock that doubles as the loop reference.
 */
package fpc_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int CNT_W  = 9;   // High or low count, 1..256
   localparam int PER_W  = 10;  // Phase length incl. fraction extra
   localparam int TUNE_W = 16;
   localparam int FRAC_W = 32;
   localparam int GAP_W  = 10;
   localparam int GOOD_W = 4;
   localparam int SRST_W = 3;

   // ----------------------------------------
   // Loop constants
   // ----------------------------------------
   localparam logic [TUNE_W-1:0] NOMINAL_TUNE = 16'h8000;
   localparam logic [TUNE_W-1:0] TUNE_STEP    = 16'h0010;
   localparam logic [TUNE_W-1:0] TUNE_MAX     = 16'hffef;
   localparam logic [TUNE_W-1:0] TUNE_MIN     = 16'h0010;
   localparam logic [GAP_W-1:0]  LOCK_WIN     = 10'h002;
   localparam logic [GAP_W-1:0]  LOSS_WIN     = 10'h010;
   localparam logic [GAP_W-1:0]  GAP_MAX      = 10'h3ff;
   localparam logic [GOOD_W-1:0] LOCK_CNT     = 4'h8;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PS       = 8000;
   localparam int SELF_RST_NS  = 32;   // Least hold of the internal reset
   localparam int SELF_RST_CYC = (SELF_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam logic [SRST_W-1:0] SELF_RST_LEN = SRST_W'(SELF_RST_CYC);

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] FW_8  = 2'h0;
   localparam logic [1:0] FW_16 = 2'h1;
   localparam logic [1:0] FW_24 = 2'h2;
   localparam logic [1:0] FW_32 = 2'h3;

   typedef enum logic [2:0] {
      CM_SRC_SYNC = 3'h0,
      CM_SERIAL   = 3'h1,
      CM_DIRECT   = 3'h2,
      CM_NORMAL   = 3'h3,
      CM_ZDB      = 3'h4,
      CM_EFB      = 3'h5
   } fpc_comp_t;

   typedef enum logic [2:0] {
      LS_RESET   = 3'b001,
      LS_ACQUIRE = 3'b010,
      LS_LOCKED  = 3'b100
   } fpc_loop_t;
endpackage

// [tb/fpc_core_model.sv]
/*
 * Core-logic model facing the loop control: pulses resync, watches lock.
 * Assumes it shares the block's clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_core_model #(
   parameter int STABLE_CYC = 16,
   parameter int PULSE_CYC  = 3
)(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic locked_in,
   input  wire logic self_reset_en_in,
   input  wire logic req_in,
   output logic      resync_out
);
   // ----------------------------------------
   // Resync pulses
   // ----------------------------------------
   int   age;
   int   left;
   logic was_locked;

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         age <= 0;
         left <= 0;
         was_locked <= 1'b0;
         resync_out <= 1'b0;
      end else begin
         was_locked <= locked_in;
         // Reference counted stable only after a settling span
         if (age < STABLE_CYC) begin
            age <= age + 1;
         end
         // Requests before the reference settles are ignored
         if (age == STABLE_CYC - 1 || (req_in && age == STABLE_CYC)) begin
            left <= PULSE_CYC;
         end else if (was_locked && !locked_in && !self_reset_en_in) begin
            left <= PULSE_CYC;
         end else if (left > 0) begin
            left <= left - 1;
         end
         resync_out <= (left > 0);
      end
   end
endmodule
`default_nettype wire

// [tb/fractional_pll_control_dividers_tb.sv]
/*
 * Self-checking bench for the fractional loop control and dividers.
 * Assumes fpc_pkg and the core-logic model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module fractional_pll_control_dividers_tb;
   import fpc_pkg::*;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic                  clk_in = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  req = 1'b0;
   logic                  self_en = 1'b0;
   fpc_comp_t             comp = CM_NORMAL;
   logic                  frac = 1'b0;
   logic [1:0]            fw = 2'h0;
   logic [31:0]           num = 32'h0;
   logic                  pre_byp = 1'b0;
   logic                  mul_byp = 1'b0;
   logic                  post = 1'b0;
   logic [CNT_W-1:0]      pre_hi = 9'h004;
   logic [CNT_W-1:0]      pre_lo = 9'h004;
   logic [CNT_W-1:0]      mul_hi = 9'h004;
   logic [CNT_W-1:0]      mul_lo = 9'h004;
   logic [3:0]            o_byp = 4'h0;
   logic [3:0][CNT_W-1:0] o_hi = {4{9'h001}};
   logic [3:0][CNT_W-1:0] o_lo = {4{9'h001}};
   logic                  locked;
   logic                  fb;
   logic                  resync;
   logic [3:0]            co;
   logic [31:0]           seed = 32'h00007e38;
   int                    n_mismatch = 0;
   int                    compares = 0;
   int                    ef;
   int                    eh;
   int                    eo [4];

   always #4 clk_in = ~clk_in;

   fpc_ctrl #(.NUM_OUT(4), .CAPTURE_IDX(0)) fpc_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n),
      .resync_in(resync), .self_reset_en_in(self_en), .comp_mode_in(comp),
      .frac_mode_in(frac), .frac_width_in(fw), .frac_num_in(num), .pre_bypass_in(pre_byp),
      .pre_hi_in(pre_hi), .pre_lo_in(pre_lo), .mul_bypass_in(mul_byp), .mul_hi_in(mul_hi),
      .mul_lo_in(mul_lo), .post_div_en_in(post), .out_bypass_in(o_byp), .out_hi_in(o_hi),
      .out_lo_in(o_lo), .locked_out(locked), .fb_clk_out(fb), .clk_out(co));

   fpc_core_model fpc_core_model_i (.clk_in(clk_in), .rst_n_in(rst_n), .locked_in(locked),
      .self_reset_en_in(self_en), .req_in(req), .resync_out(resync));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Oscillator ticks in one output period
   function automatic int ticks(input logic byp, input logic [CNT_W-1:0] hi,
                                input logic [CNT_W-1:0] lo, input logic half);
      return (byp ? 2 : int'(hi) + int'(lo)) * (half ? 2 : 1);
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wait_lock(input logic lvl);
      for (int k = 0; k < 20000 && locked !== lvl; k++) @(negedge clk_in);
   endtask

   task automatic measure;
      logic       pf;
      logic [3:0] pc;
      ef = 0;
      eh = 0;
      eo = '{0, 0, 0, 0};
      pf = fb;
      pc = co;
      repeat (2000) begin
         @(negedge clk_in);
         ef += int'(fb & !pf);
         for (int i = 0; i < 4; i++) eo[i] += int'(co[i] & !pc[i]);
         eh += int'(co[2]);
         pf = fb;
         pc = co;
      end
   endtask

   task automatic run_cfg(input string nm, input fpc_comp_t m, input logic fr,
                          input logic [1:0] w, input int pd, input int md);
      int k;
      int po;
      int pf2;
      int d;
      @(posedge clk_in);
      seed = xs(seed);
      comp <= m;
      frac <= fr;
      fw <= w;
      num <= 32'h1 << (8 * w + 7);
      pre_byp <= (pd == 1);
      pre_hi <= CNT_W'(pd - pd / 2);
      pre_lo <= CNT_W'(pd / 2);
      mul_byp <= (md == 1);
      mul_hi <= CNT_W'(md - md / 2);
      mul_lo <= CNT_W'(md / 2);
      post <= seed[0];
      for (int i = 0; i < 4; i++) begin
         o_hi[i] <= CNT_W'(seed[4 * (i | 1) +: 3]) + 9'h001;
         // Output 2 gets equal counts for the half-high case
         o_lo[i] <= CNT_W'(seed[4 * (i | 1) + (i == 2 ? 0 : 16) +: 3]) + 9'h001;
         o_byp[i] <= (i == 3) & seed[31];
      end
      req <= 1'b1;
      @(posedge clk_in);
      req <= 1'b0;
      for (k = 0; k < 10 && resync !== 1'b1; k++) @(negedge clk_in);
      @(negedge clk_in);
      check("held outputs", 32'h0, 32'({locked, fb, co}));
      for (k = 0; k < 10 && resync !== 1'b0; k++) @(negedge clk_in);
      for (k = 0; k < 20000 && locked !== 1'b1; k++) @(negedge clk_in);
      check("lock", 32'h1, {31'h0, locked});
      check("early lock", 32'h1, {31'h0, k >= 7 * pd});
      if (m == CM_SERIAL) begin
         repeat (40) begin
            @(negedge clk_in);
            check("capture inversion", {31'h0, ~co[1]}, {31'h0, co[0]});
         end
      end
      measure();
      // Bypassed multiplier toggles per tick, so its pin period is two ticks
      pf2 = (md == 1) ? 4 : 2 * md + int'(fr);
      for (int i = 0; i < 4; i++) begin
         po = ticks(o_byp[i], o_hi[i], o_lo[i], post);
         d = 2 * eo[i] * po - ef * pf2;
         check("rate", 32'h1, {31'h0, (d < 0 ? -d : d) <= 2 * (po + pf2)});
      end
      // Two clocks per tick at half ratio, so half a period is po clocks
      po = ticks(1'b0, o_hi[2], o_lo[2], post);
      d = 2 * eh - 2000;
      check("duty", 32'h1, {31'h0, (d < 0 ? -d : d) <= 2 * po + 8});
      $display("test %s done", nm);
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk_in);
      rst_n <= 1'b1;
      @(negedge clk_in);
      check("reset outputs", 32'h0, 32'({locked, fb, co}));
      for (int k = 0; k < 40 && resync !== 1'b1; k++) @(negedge clk_in);
      check("startup resync", 32'h1, {31'h0, resync});
      // Ratio one half sits at nominal tuning, so every run locks quickly
      for (int m = 0; m < 6; m++) run_cfg("mode", fpc_comp_t'(m), 1'b0, 2'h0, 8, 4);
      run_cfg("divide one", CM_DIRECT, 1'b0, 2'h0, 2, 1);
      run_cfg("divide max", CM_NORMAL, 1'b0, 2'h0, 512, 256);
      for (int w = 0; w < 4; w++) run_cfg("fraction", CM_NORMAL, 1'b1, 2'(w), 17, 8);
      run_cfg("integer", CM_NORMAL, 1'b0, 2'h3, 8, 4);
      // Live change of the multiplier forces a loss
      @(posedge clk_in);
      self_en <= 1'b1;
      mul_hi <= 9'h001;
      for (int k = 0; k < 2000 && locked !== 1'b0; k++) @(negedge clk_in);
      check("loss drop", 32'h0, {31'h0, locked});
      // Restored inside the internal reset, so relock starts aligned
      @(posedge clk_in);
      mul_hi <= 9'h002;
      for (int k = 0; k < 4 && {fb, co} !== 5'h00; k++) @(negedge clk_in);
      check("self reset", 32'h0, 32'({fb, co}));
      check("no core resync", 32'h0, {31'h0, resync});
      wait_lock(1'b1);
      check("self relock", 32'h1, {31'h0, locked});
      $display("test self reset done");
      @(posedge clk_in);
      self_en <= 1'b0;
      mul_hi <= 9'h001;
      wait_lock(1'b0);
      @(posedge clk_in);
      mul_hi <= 9'h002;
      for (int k = 0; k < 10 && resync !== 1'b1; k++) @(negedge clk_in);
      check("core resync", 32'h1, {31'h0, resync});
      wait_lock(1'b1);
      check("core relock", 32'h1, {31'h0, locked});
      $display("test core resync done");
      wrap_up();
   end

   initial begin
      repeat (95000) @(posedge clk_in);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
